/* logic/ipa_axil.sv */
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
`include "ipa_defines.svh"
module ipa_axil
	import ipa_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wrStb,
	output logic [7:0] wrAddr,
	output logic [31:0] wrData,
	output logic [3:0] wrStrb,
	input wire logic wrOk,
	output logic rdStb,
	output logic [7:0] rdAddr,
	input wire logic [31:0] rdData,
	input wire logic rdOk
);
	logic awHeld, wHeld, next_awHeld, next_wHeld, next_bvalid, next_rvalid;
	logic [7:0] next_wrAddr, next_rdAddr;
	logic [31:0] next_wrData, next_rdata;
	logic [3:0] next_wrStrb;
	logic [1:0] next_bresp, next_rresp;

	// address and data latch independently; write fires once both are held
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wrStb = awHeld && wHeld;
	assign rdStb = s_axi_arvalid && s_axi_arready;
	assign rdAddr = s_axi_araddr;

	always_comb begin
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_wrAddr = wrAddr;
		next_wrData = wrData;
		next_wrStrb = wrStrb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_wrAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wrData = s_axi_wdata;
			next_wrStrb = s_axi_wstrb;
		end
		if (wrStb) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wrOk ? 2'b00 : 2'b10; // slverr on unmapped
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (rdStb) begin
			next_rvalid = 1'b1;
			next_rdata = rdData;
			next_rresp = rdOk ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wrAddr <= 8'h00;
			wrData <= 32'h0000_0000;
			wrStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			wrAddr <= next_wrAddr;
			wrData <= next_wrData;
			wrStrb <= next_wrStrb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end
endmodule : ipa_axil
`default_nettype wire

/* logic/ipa_defines.svh */
// constants, register map and field layout of the interrupt priority autovector block
`ifndef IPA_DEFINES_SVH
`define IPA_DEFINES_SVH
`define IPA_NUM_INT 10
`define IPA_NUM_SRC 14
`define IPA_SLOTS 35
`define IPA_PER_LEVEL 5
// register byte addresses
`define IPA_ADDR_PEND 8'h00
`define IPA_ADDR_MASK 8'h04
`define IPA_ADDR_AUTOVEC 8'h08
`define IPA_ADDR_PAR 8'h0C
`define IPA_ADDR_EVST 8'h10
`define IPA_ADDR_EVCLR 8'h14
`define IPA_ADDR_EVEN 8'h18
`define IPA_ADDR_ACK 8'h1C
`define IPA_ADDR_CTRL0 8'h20
`define IPA_ADDR_CTRL_LAST 8'h44
// source control field layout
`define IPA_CTRL_AV 7
`define IPA_CTRL_LVL_HI 4
`define IPA_CTRL_LVL_LO 2
`define IPA_CTRL_PRI_HI 1
`define IPA_CTRL_PRI_LO 0
`define IPA_CTRL_WMASK 8'h9F
// pin level assignment field layout
`define IPA_PAR_PIN5 7
`define IPA_PAR_PIN3 6
`define IPA_PAR_PIN1 5
`define IPA_PAR_WMASK 8'hE0
`define IPA_AUTOVEC_SBLOCK 0
// reset values
`define IPA_RST_CTRL 8'h00
`define IPA_RST_AUTOVEC 8'h00
`define IPA_RST_PAR 8'h00
`define IPA_RST_MASK 14'h3FFF
// vector offsets
`define IPA_AV_BASE 8'h60
`define IPA_SLOT_NONE 6'h3F
// external slots
`define IPA_SLOT_P7 6'h03
`define IPA_SLOT_P3_HI 6'h08
`define IPA_SLOT_P3_LO 6'h17
`define IPA_SLOT_P5_HI 6'h0D
`define IPA_SLOT_P5_LO 6'h12
`define IPA_SLOT_P1_HI 6'h1C
`define IPA_SLOT_P1_LO 6'h21
`define IPA_LVL_7 3'h7
`define IPA_LVL_6 3'h6
`define IPA_LVL_5 3'h5
`define IPA_LVL_4 3'h4
`define IPA_LVL_3 3'h3
`define IPA_LVL_2 3'h2
`define IPA_LVL_1 3'h1
`endif

/* logic/ipa_pkg.sv */
// types shared by the interrupt priority autovector block
package ipa_pkg;
	typedef enum logic [1:0] {
		IPA_IDLE = 2'b00,
		IPA_PRESENT = 2'b01,
		IPA_ACK = 2'b10
	} ipa_state_e;
	typedef logic [5:0] ipa_slot_t;
	typedef logic [7:0] ipa_byte_t;
endpackage : ipa_pkg

/* logic/ipa_rank.sv */
// slot ranking of internal and external requests
`timescale 1ns/1ps
`default_nettype none
`include "ipa_defines.svh"
module ipa_rank
	import ipa_pkg::*;
(
	input wire logic [`IPA_NUM_INT*8-1:0] srcCtrl,
	input wire logic [`IPA_NUM_SRC-1:0] active,
	input wire logic [7:0] pinLevelAssign,
	output logic anyReq,
	output logic [3:0] winIdx,
	output ipa_slot_t winSlot,
	output logic [2:0] winLevel
);
	// slot of an internal source from its level and priority fields
	function automatic ipa_slot_t intSlot(input logic [7:0] c);
		logic [5:0] base;
		logic [5:0] off;
		base = 6'(`IPA_LVL_7 - c[`IPA_CTRL_LVL_HI:`IPA_CTRL_LVL_LO]) * 6'(`IPA_PER_LEVEL);
		case (c[`IPA_CTRL_PRI_HI:`IPA_CTRL_PRI_LO])
			2'h3: off = 6'h01;
			2'h2: off = 6'h02;
			2'h1: off = 6'h04;
			default: off = 6'h05;
		endcase
		// level 0 never requests
		if (c[`IPA_CTRL_LVL_HI:`IPA_CTRL_LVL_LO] == 3'h0) begin
			intSlot = `IPA_SLOT_NONE;
		end else begin
			intSlot = base + off;
		end
	endfunction : intSlot

	ipa_slot_t slot [`IPA_NUM_SRC];
	logic [2:0] lvl [`IPA_NUM_SRC];

	genvar g;
	generate
		for (g = 0; g < `IPA_NUM_INT; g++) begin : gInt
			assign slot[g] = intSlot(srcCtrl[g*8 +: 8]);
			assign lvl[g] = srcCtrl[g*8+`IPA_CTRL_LVL_LO +: 3];
		end
	endgenerate

	// external pins 7, 5, 3, 1 follow the internal sources
	assign slot[10] = `IPA_SLOT_P7;
	assign lvl[10] = `IPA_LVL_7;
	assign slot[11] = pinLevelAssign[`IPA_PAR_PIN5] ? `IPA_SLOT_P5_LO : `IPA_SLOT_P5_HI;
	assign lvl[11] = pinLevelAssign[`IPA_PAR_PIN5] ? `IPA_LVL_4 : `IPA_LVL_5;
	assign slot[12] = pinLevelAssign[`IPA_PAR_PIN3] ? `IPA_SLOT_P3_HI : `IPA_SLOT_P3_LO;
	assign lvl[12] = pinLevelAssign[`IPA_PAR_PIN3] ? `IPA_LVL_6 : `IPA_LVL_3;
	assign slot[13] = pinLevelAssign[`IPA_PAR_PIN1] ? `IPA_SLOT_P1_HI : `IPA_SLOT_P1_LO;
	assign lvl[13] = pinLevelAssign[`IPA_PAR_PIN1] ? `IPA_LVL_2 : `IPA_LVL_1;

	// lowest slot wins; duplicate slots resolve to the lower index, undefined by contract
	always_comb begin
		anyReq = 1'b0;
		winIdx = 4'h0;
		winSlot = `IPA_SLOT_NONE;
		winLevel = 3'h0;
		for (int i = 0; i < `IPA_NUM_SRC; i++) begin
			if (active[i] && slot[i] < winSlot) begin
				anyReq = 1'b1;
				winIdx = 4'(i);
				winSlot = slot[i];
				winLevel = lvl[i];
			end
		end
	end
endmodule : ipa_rank
`default_nettype wire

/* logic/ipa_top.sv */
// interrupt priority resolution and autovector control top level
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ipa_defines.svh"
module ipa_top
	import ipa_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [`IPA_NUM_INT-1:0] intReq,
	input wire logic ext_request_pin_7,
	input wire logic ext_request_pin_5,
	input wire logic ext_request_pin_3,
	input wire logic ext_request_pin_1,
	output logic coreReq,
	output logic [2:0] coreLevel,
	input wire logic ackStart,
	input wire logic ackDone,
	output logic ackAutovector,
	output logic [7:0] ackVectorOffset,
	output logic [3:0] ackSource,
	output logic address_strobe_block,
	output logic irq
);
	ipa_byte_t srcCtrl [`IPA_NUM_INT];
	ipa_byte_t external_autovector_control, pin_level_assign;
	logic [`IPA_NUM_SRC-1:0] source_mask, source_pending;
	logic [2:0] evStatus, evEnable;
	ipa_state_e state;
	logic [3:0] curIdx;
	logic [2:0] curLevel;
	logic wrStb, rdStb, wrOk, rdOk;
	logic [7:0] wrAddr, rdAddr;
	logic [31:0] wrData, rdData;
	logic [3:0] wrStrb;
	logic [`IPA_NUM_INT*8-1:0] ctrlFlat;
	logic [`IPA_NUM_SRC-1:0] rawReq, active;
	logic anyReq;
	logic [3:0] winIdx;
	ipa_slot_t winSlot;
	logic [2:0] winLevel;

	ipa_byte_t next_srcCtrl [`IPA_NUM_INT];
	ipa_byte_t next_autovec, next_par;
	logic [`IPA_NUM_SRC-1:0] next_mask, next_pending;
	logic [2:0] next_evStatus, next_evEnable;
	ipa_state_e next_state;
	logic [3:0] next_curIdx;
	logic [2:0] next_curLevel;
	logic next_ackAv, next_strobeBlock;
	logic [7:0] next_vec;
	logic [2:0] evSet;

	// true when an external pin sits at the given level under current assignment
	function automatic logic extAtLevel(input logic [2:0] l, input ipa_byte_t par);
		case (l)
			`IPA_LVL_7: extAtLevel = 1'b1;
			`IPA_LVL_6: extAtLevel = par[`IPA_PAR_PIN3];
			`IPA_LVL_5: extAtLevel = !par[`IPA_PAR_PIN5];
			`IPA_LVL_4: extAtLevel = par[`IPA_PAR_PIN5];
			`IPA_LVL_3: extAtLevel = !par[`IPA_PAR_PIN3];
			`IPA_LVL_2: extAtLevel = par[`IPA_PAR_PIN1];
			`IPA_LVL_1: extAtLevel = !par[`IPA_PAR_PIN1];
			default: extAtLevel = 1'b0;
		endcase
	endfunction : extAtLevel

	// byte-lane merge for writes
	function automatic ipa_byte_t laneMerge(input ipa_byte_t old, input logic [7:0] d,
		input logic s, input ipa_byte_t wm);
		laneMerge = s ? (d & wm) : old;
	endfunction : laneMerge

	////////////////////////////////////////////////////////////////////////////////
	// bus slave
	ipa_axil ipa_axil_inst (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wrStb(wrStb),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.wrStrb(wrStrb),
		.wrOk(wrOk),
		.rdStb(rdStb),
		.rdAddr(rdAddr),
		.rdData(rdData),
		.rdOk(rdOk)
	);

	// pin 7, 5, 3, 1 take source indices 10..13
	assign rawReq = {ext_request_pin_1, ext_request_pin_3, ext_request_pin_5,
		ext_request_pin_7, intReq};
	assign active = source_pending & ~source_mask;

	genvar g;
	generate
		for (g = 0; g < `IPA_NUM_INT; g++) begin : gFlat
			assign ctrlFlat[g*8 +: 8] = srcCtrl[g];
		end
	endgenerate

	ipa_rank ipa_rank_inst (
		.srcCtrl(ctrlFlat),
		.active(active),
		.pinLevelAssign(pin_level_assign),
		.anyReq(anyReq),
		.winIdx(winIdx),
		.winSlot(winSlot),
		.winLevel(winLevel)
	);

	////////////////////////////////////////////////////////////////////////////////
	// register read decode; pending and status show live state
	always_comb begin
		rdData = 32'h0000_0000;
		rdOk = 1'b1;
		wrOk = (wrAddr <= `IPA_ADDR_CTRL_LAST) && (wrAddr[1:0] == 2'h0);
		if (rdAddr >= `IPA_ADDR_CTRL0 && rdAddr <= `IPA_ADDR_CTRL_LAST && rdAddr[1:0] == 2'h0) begin
			rdData = {24'h00_0000, srcCtrl[4'((rdAddr - `IPA_ADDR_CTRL0) >> 2)]};
		end else begin
			case (rdAddr)
				`IPA_ADDR_PEND: rdData = {18'h0_0000, source_pending};
				`IPA_ADDR_MASK: rdData = {18'h0_0000, source_mask};
				`IPA_ADDR_AUTOVEC: rdData = {24'h00_0000, external_autovector_control};
				`IPA_ADDR_PAR: rdData = {24'h00_0000, pin_level_assign};
				`IPA_ADDR_EVST: rdData = {29'h0000_0000, evStatus};
				`IPA_ADDR_EVCLR: rdData = 32'h0000_0000; // write-only
				`IPA_ADDR_EVEN: rdData = {29'h0000_0000, evEnable};
				`IPA_ADDR_ACK: rdData = {20'h0_0000, 2'(state), curLevel, 3'h0, curIdx};
				default: rdOk = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers and sampled pending bits
	always_comb begin
		next_autovec = external_autovector_control;
		next_par = pin_level_assign;
		next_mask = source_mask;
		next_pending = rawReq; // pending follows the request each clock
		for (int i = 0; i < `IPA_NUM_INT; i++) begin
			next_srcCtrl[i] = srcCtrl[i];
		end
		if (wrStb && wrOk) begin
			if (wrAddr >= `IPA_ADDR_CTRL0) begin
				next_srcCtrl[4'((wrAddr - `IPA_ADDR_CTRL0) >> 2)] = laneMerge(
					srcCtrl[4'((wrAddr - `IPA_ADDR_CTRL0) >> 2)], wrData[7:0], wrStrb[0],
					`IPA_CTRL_WMASK);
			end else begin
				case (wrAddr)
					`IPA_ADDR_AUTOVEC: next_autovec = laneMerge(external_autovector_control,
						wrData[7:0], wrStrb[0], 8'hFF);
					`IPA_ADDR_PAR: next_par = laneMerge(pin_level_assign, wrData[7:0],
						wrStrb[0], `IPA_PAR_WMASK);
					`IPA_ADDR_MASK: begin
						if (wrStrb[0]) next_mask[7:0] = wrData[7:0];
						if (wrStrb[1]) next_mask[13:8] = wrData[13:8];
					end
					default: next_autovec = external_autovector_control;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `IPA_NUM_INT; i++) srcCtrl[i] <= `IPA_RST_CTRL;
			external_autovector_control <= `IPA_RST_AUTOVEC;
			pin_level_assign <= `IPA_RST_PAR;
			source_mask <= `IPA_RST_MASK;
			source_pending <= 14'h0000;
		end else begin
			for (int i = 0; i < `IPA_NUM_INT; i++) srcCtrl[i] <= next_srcCtrl[i];
			external_autovector_control <= next_autovec;
			pin_level_assign <= next_par;
			source_mask <= next_mask;
			source_pending <= next_pending;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// presentation and acknowledge sequence; winner frozen only during acknowledge
	always_comb begin
		next_state = state;
		next_curIdx = curIdx;
		next_curLevel = curLevel;
		next_ackAv = ackAutovector;
		next_vec = ackVectorOffset;
		next_strobeBlock = address_strobe_block;
		case (state)
			IPA_IDLE, IPA_PRESENT: begin
				// re-rank every cycle so a newly higher request takes over
				next_state = anyReq ? IPA_PRESENT : IPA_IDLE;
				next_curIdx = winIdx;
				next_curLevel = anyReq ? winLevel : 3'h0;
				if (state == IPA_PRESENT && ackStart) begin
					next_state = IPA_ACK;
					next_curIdx = curIdx;
					next_curLevel = curLevel;
					if (curIdx < 4'(`IPA_NUM_INT)) begin
						next_ackAv = srcCtrl[curIdx][`IPA_CTRL_AV];
						next_strobeBlock = 1'b0;
					end else begin
						next_ackAv = external_autovector_control[curLevel] &&
							extAtLevel(curLevel, pin_level_assign);
						next_strobeBlock = next_ackAv &&
							external_autovector_control[`IPA_AUTOVEC_SBLOCK];
					end
					next_vec = next_ackAv ? (`IPA_AV_BASE + {3'h0, curLevel, 2'h0}) : 8'h00;
				end
			end
			IPA_ACK: begin
				if (ackDone) begin
					next_state = IPA_IDLE;
					next_ackAv = 1'b0;
					next_vec = 8'h00;
					next_strobeBlock = 1'b0;
				end
			end
			default: next_state = IPA_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= IPA_IDLE;
			curIdx <= 4'h0;
			curLevel <= 3'h0;
			ackAutovector <= 1'b0;
			ackVectorOffset <= 8'h00;
			address_strobe_block <= 1'b0;
		end else begin
			state <= next_state;
			curIdx <= next_curIdx;
			curLevel <= next_curLevel;
			ackAutovector <= next_ackAv;
			ackVectorOffset <= next_vec;
			address_strobe_block <= next_strobeBlock;
		end
	end

	assign coreReq = (state != IPA_IDLE);
	assign coreLevel = curLevel;
	assign ackSource = curIdx;

	////////////////////////////////////////////////////////////////////////////////
	// event flags: 0 acknowledge begun, 1 autovector issued, 2 acknowledge done
	assign evSet = {state == IPA_ACK && ackDone,
		state == IPA_PRESENT && ackStart && next_ackAv,
		state == IPA_PRESENT && ackStart};

	// set beats clear in the same cycle
	always_comb begin
		next_evStatus = evStatus;
		next_evEnable = evEnable;
		if (wrStb && wrOk && wrStrb[0]) begin
			if (wrAddr == `IPA_ADDR_EVCLR) next_evStatus = evStatus & ~wrData[2:0];
			if (wrAddr == `IPA_ADDR_EVEN) next_evEnable = wrData[2:0];
		end
		next_evStatus = next_evStatus | evSet;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			evStatus <= 3'h0;
			evEnable <= 3'h0;
		end else begin
			evStatus <= next_evStatus;
			evEnable <= next_evEnable;
		end
	end

	assign irq = |(evStatus & evEnable);
endmodule : ipa_top
`default_nettype wire

/* verification/interrupt_priority_autovector_tb.sv */
// self-checking testbench for the interrupt priority autovector block
`timescale 1ns/1ps
`default_nettype none
`include "ipa_defines.svh"
module interrupt_priority_autovector_tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, coreReq, ackStart, ackDone, ackAv, strobeHold, irq;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [9:0] intReq = 10'h000;
	logic [3:0] pins = 4'h0; // pin 7, 5, 3, 1 = sources 10..13
	logic [3:0] waitCyc = 4'h0;
	logic [2:0] coreLevel;
	logic [7:0] avOff;
	logic [3:0] ackSrc;
	logic [16:0] seen;
	logic [2:0] lvLo[4] = '{3'h7, 3'h5, 3'h3, 3'h1};
	logic [2:0] lvHi[4] = '{3'h7, 3'h4, 3'h6, 3'h2};
	logic [7:0] avTab[6] = '{8'h00, 8'h00, 8'hFF, 8'hFE, 8'h54, 8'h2A};
	logic [7:0] ctlTab[8] = '{8'h9B, 8'h1A, 8'h19, 8'h18, 8'h1C, 8'h1E, 8'h00, 8'h0F};
	logic [3:0] ordSrc[8] = '{4'h5, 4'hA, 4'h4, 4'h0, 4'h1, 4'hC, 4'h2, 4'h3};
	int errTotal = 0;
	int nCompared = 0;
	ipa_top ipa_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .intReq(intReq),
		.ext_request_pin_7(pins[0]), .ext_request_pin_5(pins[1]), .ext_request_pin_3(pins[2]),
		.ext_request_pin_1(pins[3]), .coreReq(coreReq), .coreLevel(coreLevel),
		.ackStart(ackStart), .ackDone(ackDone), .ackAutovector(ackAv), .ackVectorOffset(avOff),
		.ackSource(ackSrc), .address_strobe_block(strobeHold), .irq(irq));
	ipa_core_model ipa_core_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .coreReq(coreReq),
		.coreLevel(coreLevel), .ackAutovector(ackAv), .ackVectorOffset(avOff),
		.ackSource(ackSrc), .address_strobe_block(strobeHold), .waitCyc(waitCyc),
		.ackStart(ackStart), .ackDone(ackDone), .seen(seen));
	////////////////////////////////////////////////////////////////
	// free-running clock
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic giveVerdict();
		if (errTotal == 0 && nCompared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : giveVerdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			errTotal++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	////////////////////////////////////////////////////////////////
	// bus master: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aDone;
		logic wDone;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aDone = 1'b0;
		wDone = 1'b0;
		while (!(aDone && wDone)) begin
			@(posedge sys_clk);
			if (!aDone && awready) begin
				awvalid <= 1'b0;
				aDone = 1'b1;
			end
			if (!wDone && wready) begin
				wvalid <= 1'b0;
				wDone = 1'b1;
			end
		end
		do @(posedge sys_clk); while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge sys_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (!rvalid);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		chk(rd, exp);
		chk({30'h0, resp}, 32'h0);
	endtask : rc
	// source drops its request once acknowledged, then the capture is compared
	task automatic ackChk(input logic [3:0] src, input logic [2:0] lvl, input logic av,
		input logic bl);
		@(posedge ackDone);
		if (src > 4'h9) pins[src - 4'hA] <= 1'b0;
		else intReq[src] <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk({15'h0, seen}, {15'h0, bl, av, lvl, src, av ? 8'h60 + {3'h0, lvl, 2'h0} : 8'h00});
	endtask : ackChk
	////////////////////////////////////////////////////////////////
	// hang guard, well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge sys_clk);
		errTotal++;
		giveVerdict();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		rc(`IPA_ADDR_MASK, 32'h3FFF);
		rc(`IPA_ADDR_AUTOVEC, 32'h0);
		wr(`IPA_ADDR_PAR, 32'hFF);
		rc(`IPA_ADDR_PAR, 32'hE0);
		wr(`IPA_ADDR_CTRL0, 32'hFF);
		rc(`IPA_ADDR_CTRL0, 32'h9F);
		wr(`IPA_ADDR_CTRL0, 32'h0);
		wr(8'h80, 32'h1);
		chk({30'h0, resp}, 32'h2);
		rc(`IPA_ADDR_EVCLR, 32'h0);
		wr(`IPA_ADDR_MASK, 32'h0);
		// every pin under both assignments and five autovector settings
		for (int m = 0; m < 6; m++) begin
			wr(`IPA_ADDR_PAR, m[0] ? 32'hE0 : 32'h0);
			wr(`IPA_ADDR_AUTOVEC, {24'h0, avTab[m]});
			for (int p = 0; p < 4; p++) begin
				waitCyc <= m[1] ? 4'h3 : 4'h0;
				pins[p] <= 1'b1;
				ackChk(4'hA + 4'(p), m[0] ? lvHi[p] : lvLo[p], m[2:1] == 2'h1, m == 2);
			end
		end
		// eight requests at once drain in slot order, source 7 masked
		wr(`IPA_ADDR_PAR, 32'h40);
		wr(`IPA_ADDR_AUTOVEC, 32'h0);
		for (int s = 0; s < 8; s++) wr(`IPA_ADDR_CTRL0 + 8'(4 * s), {24'h0, ctlTab[s]});
		wr(`IPA_ADDR_MASK, 32'h80);
		intReq <= 10'h0BF;
		pins <= 4'h5;
		for (int s = 0; s < 8; s++) ackChk(ordSrc[s], s < 3 ? 3'h7 : 3'h6, ordSrc[s] == 0, 1'b0);
		rc(`IPA_ADDR_PEND, 32'h80);
		chk({31'h0, coreReq}, 32'h0);
		wr(`IPA_ADDR_MASK, 32'h0);
		ackChk(4'h7, 3'h3, 1'b0, 1'b0);
		// event status, enable and clear behind the interrupt line
		rc(`IPA_ADDR_EVST, 32'h7);
		chk({31'h0, irq}, 32'h0);
		wr(`IPA_ADDR_EVEN, 32'h2);
		chk({31'h0, irq}, 32'h1);
		wr(`IPA_ADDR_EVCLR, 32'h2);
		chk({31'h0, irq}, 32'h0);
		rc(`IPA_ADDR_EVST, 32'h5);
		giveVerdict();
	end
endmodule : interrupt_priority_autovector_tb
`default_nettype wire

/* verification/ipa_core_model.sv */
// behavioural processor core that acknowledges presented interrupts
`timescale 1ns/1ps
`default_nettype none
module ipa_core_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic coreReq,
	input wire logic [2:0] coreLevel,
	input wire logic ackAutovector,
	input wire logic [7:0] ackVectorOffset,
	input wire logic [3:0] ackSource,
	input wire logic address_strobe_block,
	input wire logic [3:0] waitCyc,
	output logic ackStart,
	output logic ackDone,
	output logic [16:0] seen
);
	////////////////////////////////////////////////////////////////
	// one acknowledge at a time; waitCyc stalls the start like a busy core
	initial begin
		ackStart = 1'b0;
		ackDone = 1'b0;
		seen = 17'h0;
	end
	always begin
		@(posedge sys_clk);
		if (rst_n && coreReq) begin
			repeat (waitCyc) @(posedge sys_clk);
			ackStart <= 1'b1;
			@(posedge sys_clk);
			ackStart <= 1'b0;
			@(posedge sys_clk);
			// answer is valid from the cycle after the start is taken until the done is taken
			seen <= {address_strobe_block, ackAutovector, coreLevel, ackSource, ackVectorOffset};
			ackDone <= 1'b1;
			@(posedge sys_clk);
			ackDone <= 1'b0;
		end
	end
endmodule : ipa_core_model
`default_nettype wire

/* verification/ipa_top_props.sv */
// assertion checker for the interrupt priority autovector top level
`timescale 1ns/1ps
`default_nettype none
module ipa_top_props (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic coreReq,
	input wire logic [2:0] coreLevel,
	input wire logic ackStart,
	input wire logic ackDone,
	input wire logic ackAutovector,
	input wire logic [7:0] ackVectorOffset,
	input wire logic [3:0] ackSource,
	input wire logic address_strobe_block
);
	logic inAck;
	logic next_inAck;
	////////////////////////////////////////////////////////////////
	// acknowledge window as the core sees it, start only while presented
	always_comb begin
		next_inAck = inAck;
		if (inAck && ackDone) next_inAck = 1'b0;
		else if (!inAck && coreReq && ackStart) next_inAck = 1'b1;
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) inAck <= 1'b0;
		else inAck <= next_inAck;
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_offset;
		ackAutovector |-> coreLevel != 3'h0 && ackVectorOffset == 8'h60 + {3'h0, coreLevel, 2'h0};
	endproperty
	a_offset: assert property (p_offset) else $error("autovector offset wrong");
	property p_noOffset;
		inAck && !ackAutovector |-> ackVectorOffset == 8'h00;
	endproperty
	a_noOffset: assert property (p_noOffset) else $error("offset without autovector");
	property p_block;
		address_strobe_block |-> ackAutovector && ackSource >= 4'hA;
	endproperty
	a_block: assert property (p_block) else $error("strobe block off external");
	property p_pin7;
		inAck && ackSource == 4'hA |-> coreLevel == 3'h7;
	endproperty
	a_pin7: assert property (p_pin7) else $error("pin 7 level wrong");
	property p_pin3;
		inAck && ackSource == 4'hC |-> coreLevel inside {3'h6, 3'h3};
	endproperty
	a_pin3: assert property (p_pin3) else $error("pin 3 level wrong");
	property p_pin5;
		inAck && ackSource == 4'hB |-> coreLevel inside {3'h5, 3'h4};
	endproperty
	a_pin5: assert property (p_pin5) else $error("pin 5 level wrong");
	property p_pin1;
		inAck && ackSource == 4'hD |-> coreLevel inside {3'h1, 3'h2};
	endproperty
	a_pin1: assert property (p_pin1) else $error("pin 1 level wrong");
	property p_frozen;
		inAck && !ackDone |=> $stable(ackSource) && $stable(coreLevel);
	endproperty
	a_frozen: assert property (p_frozen) else $error("winner moved in acknowledge");
	property p_held;
		inAck |-> coreReq;
	endproperty
	a_held: assert property (p_held) else $error("request dropped in acknowledge");
endmodule : ipa_top_props
bind ipa_top ipa_top_props ipa_top_props_inst (.sys_clk, .rst_n, .coreReq, .coreLevel,
	.ackStart, .ackDone, .ackAutovector, .ackVectorOffset, .ackSource, .address_strobe_block);
`default_nettype wire
